// [fpep_pkg.sv]
// Constants shared by the flash program/erase protection block
`default_nettype none
package fpep_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] FPEP_OFS_CTRL       = 8'h00;
  localparam logic [7:0] FPEP_OFS_BLK_FIRST  = 8'h04;
  localparam logic [7:0] FPEP_OFS_BLK_SECOND = 8'h08;
  localparam logic [7:0] FPEP_OFS_WAIT       = 8'h0C;
  localparam logic [7:0] FPEP_OFS_STATUS     = 8'h10;
  localparam logic [7:0] FPEP_ADDR_MASK      = 8'hFC;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FPEP_CTRL_PROG   = 0;
  localparam int FPEP_CTRL_ERASE  = 1;
  localparam int FPEP_CTRL_PCHK   = 2;
  localparam int FPEP_CTRL_ECHK   = 3;
  localparam int FPEP_WAIT_OVL_HI = 7;
  localparam int FPEP_WAIT_OVL_LO = 6;

  // ---------------------------------------------------------------
  // Reset values, masks and bus encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] FPEP_CTRL_RST       = 8'h00;
  localparam logic [7:0] FPEP_CTRL_MASK      = 8'h0F;
  localparam logic [7:0] FPEP_BLK_FIRST_RST  = 8'hF0;
  localparam logic [7:0] FPEP_BLK_FIRST_RSVD = 8'hF0;
  localparam logic [7:0] FPEP_BLK_SECOND_RST = 8'h00;
  localparam logic [7:0] FPEP_WAIT_RST       = 8'h08;
  localparam logic [1:0] FPEP_HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0] FPEP_HSIZE_WORD     = 3'h2;
endpackage : fpep_pkg
`default_nettype wire

// [fpep_core.sv]
// Flash program/erase control and protection with AHB-Lite registers
`default_nettype none
module fpep_core
  import fpep_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        program_voltage_pin,
  input  wire logic        standby_req,
  input  wire logic        watchdog_reset,
  input  wire logic        irq_in,
  output var  logic        program_pulse,
  output var  logic        erase_pulse,
  output var  logic        verify_en,
  output var  logic        prewrite_verify,
  output var  logic        busy,
  output var  logic        aborted,
  output var  logic        overlap_vectors,
  output var  logic [11:0] block_en
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  blk_first;
    logic [7:0]  blk_second;
    logic [7:0]  wait_ctrl;
    logic        aborted;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic        ready;
    logic        prog_pulse;
    logic        erase_pulse;
    logic        verify_en;
    logic        prewrite;
    logic        busy;
    logic        ovl_vec;
    logic        emu_prot;
    logic [11:0] blk_en;
  } fpep_state_t;

  fpep_state_t st;
  fpep_state_t next_st;
  logic        hw_init;
  logic        addr_ok;

  // Register select, used by both read and write paths
  function automatic logic fpep_hit(input logic [7:0] a,
                                    input logic [7:0] ofs);
    fpep_hit = ((a & FPEP_ADDR_MASK) == ofs);
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_st         = st;
    next_st.ready   = 1'b1;
    next_st.wr_pend = 1'b0;
    hw_init = ~program_voltage_pin | standby_req | watchdog_reset;
    addr_ok = hsel & hready & (htrans == FPEP_HTRANS_NONSEQ);
    // Data phase of a write lands in the addressed register
    if (st.wr_pend) begin
      if (fpep_hit(st.wr_addr, FPEP_OFS_CTRL)) begin
        next_st.ctrl = hwdata[7:0] & FPEP_CTRL_MASK;
      end
      if (fpep_hit(st.wr_addr, FPEP_OFS_BLK_FIRST)) begin
        next_st.blk_first = hwdata[7:0] | FPEP_BLK_FIRST_RSVD;
      end
      if (fpep_hit(st.wr_addr, FPEP_OFS_BLK_SECOND)) begin
        next_st.blk_second = hwdata[7:0];
      end
      if (fpep_hit(st.wr_addr, FPEP_OFS_WAIT)) begin
        next_st.wait_ctrl = hwdata[7:0];
      end
    end
    // No 12 V, standby or watchdog reset clears ctrl, blk_first and blk_second; wait_ctrl keeps its value
    if (hw_init) begin
      next_st.ctrl       = FPEP_CTRL_RST;
      next_st.blk_first  = FPEP_BLK_FIRST_RST;
      next_st.blk_second = FPEP_BLK_SECOND_RST;
    end
    // Interrupt during program or erase latches the abort
    if (irq_in & st.busy) begin
      next_st.aborted = 1'b1;
    end
    // Address phase: latch writes, fetch read data
    if (addr_ok & hwrite & (hsize == FPEP_HSIZE_WORD)) begin
      next_st.wr_pend = 1'b1;
      next_st.wr_addr = haddr[7:0];
    end
    if (addr_ok & ~hwrite) begin
      next_st.rdata = 32'h0000_0000;
      if (fpep_hit(haddr[7:0], FPEP_OFS_CTRL)) begin
        next_st.rdata[7:0] = next_st.ctrl;
      end
      if (fpep_hit(haddr[7:0], FPEP_OFS_BLK_FIRST)) begin
        next_st.rdata[7:0] = next_st.blk_first;
      end
      if (fpep_hit(haddr[7:0], FPEP_OFS_BLK_SECOND)) begin
        next_st.rdata[7:0] = next_st.blk_second;
      end
      if (fpep_hit(haddr[7:0], FPEP_OFS_WAIT)) begin
        next_st.rdata[7:0] = next_st.wait_ctrl;
      end
      if (fpep_hit(haddr[7:0], FPEP_OFS_STATUS)) begin
        next_st.rdata[7:0] = {5'h00, program_voltage_pin, next_st.aborted,
                              next_st.ctrl[FPEP_CTRL_PROG]
                              | next_st.ctrl[FPEP_CTRL_ERASE]};
      end
    end
    // Derived controls
    next_st.busy = next_st.ctrl[FPEP_CTRL_PROG]
                 | next_st.ctrl[FPEP_CTRL_ERASE];
    next_st.emu_prot = next_st.wait_ctrl[FPEP_WAIT_OVL_HI]
                     ^ next_st.wait_ctrl[FPEP_WAIT_OVL_LO];
    next_st.ovl_vec = next_st.wait_ctrl[FPEP_WAIT_OVL_HI]
                    & next_st.wait_ctrl[FPEP_WAIT_OVL_LO];
    // Selected blocks, cleared by any protection
    next_st.blk_en = {next_st.blk_first[3:0], next_st.blk_second};
    if (next_st.emu_prot | next_st.aborted | hw_init) begin
      next_st.blk_en = 12'h000;
    end
    next_st.prog_pulse = next_st.ctrl[FPEP_CTRL_PROG]
                       & (|next_st.blk_en);
    next_st.erase_pulse = next_st.ctrl[FPEP_CTRL_ERASE]
                        & ~next_st.ctrl[FPEP_CTRL_PROG]
                        & (|next_st.blk_en);
    // Verify paths need 12 V; abort leaves them usable
    next_st.prewrite = ~hw_init
                     & ((next_st.ctrl & FPEP_CTRL_MASK) == 8'h00);
    next_st.verify_en = ~hw_init & (next_st.prewrite
                      | next_st.ctrl[FPEP_CTRL_PCHK]
                      | next_st.ctrl[FPEP_CTRL_ECHK]);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st            <= '0;
      st.blk_first  <= FPEP_BLK_FIRST_RST;
      st.wait_ctrl  <= FPEP_WAIT_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops; hresp is tied low
  assign hrdata          = st.rdata;
  assign hreadyout       = st.ready;
  assign hresp           = 1'b0;
  assign program_pulse   = st.prog_pulse;
  assign erase_pulse     = st.erase_pulse;
  assign verify_en       = st.verify_en;
  assign prewrite_verify = st.prewrite;
  assign busy            = st.busy;
  assign aborted         = st.aborted;
  assign overlap_vectors = st.ovl_vec;
  assign block_en        = st.blk_en;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking fpep_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_no_vpp;
    !program_voltage_pin |=> st.ctrl == FPEP_CTRL_RST
      && st.blk_second == FPEP_BLK_SECOND_RST && !verify_en;
  endproperty
  a_no_vpp: assert property (p_no_vpp)
    else $error("registers not held without 12 V");

  property p_init;
    (standby_req || watchdog_reset) |=> st.ctrl == FPEP_CTRL_RST
      && st.blk_first == FPEP_BLK_FIRST_RST && !busy;
  endproperty
  a_init: assert property (p_init)
    else $error("standby or watchdog did not initialise");

  property p_abort;
    irq_in && busy |=> aborted ##1 (!program_pulse && !erase_pulse)[*3];
  endproperty
  a_abort: assert property (p_abort)
    else $error("interrupt did not abort the pulse");

  // Emulation protect flag, watched by the next check
  logic emu_prot_chk;
  assign emu_prot_chk = st.emu_prot;
  property p_emu;
    emu_prot_chk |-> block_en == 12'h000 && !program_pulse;
  endproperty
  a_emu: assert property (p_emu)
    else $error("emulation protect let a block through");

  property p_blocks;
    (st.blk_first[3:0] == 4'h0 && st.blk_second == 8'h00)
      |-> !program_pulse && !erase_pulse;
  endproperty
  a_blocks: assert property (p_blocks)
    else $error("pulse with no block selected");

  property p_pulse;
    program_pulse |-> st.ctrl[FPEP_CTRL_PROG] && !aborted
      && !st.emu_prot && $past(program_voltage_pin);
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("program pulse without cause");

  property p_prewrite;
    prewrite_verify |-> verify_en && (st.ctrl & FPEP_CTRL_MASK) == 8'h00;
  endproperty
  a_prewrite: assert property (p_prewrite)
    else $error("prewrite verify with a mode bit set");

  property p_busy;
    busy == (st.ctrl[FPEP_CTRL_PROG] || st.ctrl[FPEP_CTRL_ERASE]);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy does not follow program or erase bit");

  property p_overlap;
    overlap_vectors |-> st.wait_ctrl[FPEP_WAIT_OVL_HI]
      && st.wait_ctrl[FPEP_WAIT_OVL_LO] && !st.emu_prot;
  endproperty
  a_overlap: assert property (p_overlap)
    else $error("vector overlap without both select bits");

  c_prog: cover property (program_pulse ##1 !program_pulse);
  c_erase: cover property (erase_pulse);
  c_abort: cover property (busy && irq_in ##1 aborted);
  c_prewrite: cover property (program_pulse ##1 prewrite_verify);

endmodule // fpep_core
`default_nettype wire

// [fpep_proc.sv]
// Processor model issuing register transfers over AHB-Lite
`default_nettype none
module fpep_proc
  import fpep_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // Routine timing at the 25 ns clock, in cycles
  localparam int PROG_PULSE_CYC  = 800;  // 20 us ceiling
  localparam int ERASE_PULSE_CYC = 1000; // Far short of the 10 ms ceiling
  localparam int SETUP_LONG_CYC  = 160;  // 4 us floor
  localparam int SETUP_SHORT_CYC = 80;   // 2 us floor
  localparam int MAX_TRIES       = 50;   // 50 x 20 us stays within 1 ms
  // Guard timer load the routine uses for a 10 to 16 MHz clock
  localparam logic [15:0] GUARD_LOAD = 16'hA57F;
  int tries;
  // Bus idle at time zero
  initial begin
    tries  = 0;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h0;
    hwdata = 32'h0;
  end
  // Single word transfer; read data taken at end of data phase
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= FPEP_HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= FPEP_HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  // Start a pulse (a program one only while tries < MAX_TRIES) and hold it for half of PROG_PULSE_CYC or ERASE_PULSE_CYC; caller ends it
  task automatic start_pulse(input logic [7:0] mode);
    logic [31:0] q;
    if (mode[FPEP_CTRL_ERASE]) begin
      xfer(1'b1, FPEP_OFS_CTRL, mode, q);
      repeat (ERASE_PULSE_CYC / 2) @(posedge hclk);
    end else if (tries < MAX_TRIES) begin
      tries++;
      xfer(1'b1, FPEP_OFS_CTRL, mode, q);
      repeat (PROG_PULSE_CYC / 2) @(posedge hclk);
    end
  endtask
  // Leave the pulse for a verify mode and wait out its set-up time
  task automatic enter_verify(input logic [7:0] mode);
    logic [31:0] q;
    xfer(1'b1, FPEP_OFS_CTRL, mode, q);
    if (mode == 8'h00 || mode[FPEP_CTRL_PCHK]) begin
      repeat (SETUP_LONG_CYC) @(posedge hclk);
    end else begin
      repeat (SETUP_SHORT_CYC) @(posedge hclk);
    end
  endtask
endmodule // fpep_proc
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the flash program/erase protection block
`default_nettype none
module tb_top
  import fpep_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, vpp, stby, wdr, irq;
  logic        prog_p, erase_p, ver, prew, busy, abrt, ovl, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [11:0] blk;
  logic [31:0] haddr, hwdata, hrdata, q;
  int          mismatches, cmp_count;

  // ---------------------------------------------------------------
  // Clock, pins and instances
  // ---------------------------------------------------------------
  always #12.5 hclk = ~hclk;
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    vpp = 1'b1;
    stby = 1'b0;
    wdr = 1'b0;
    irq = 1'b0;
  end
  fpep_proc u_fpep_proc (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));
  fpep_core u_fpep_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .program_voltage_pin(vpp),
    .standby_req(stby), .watchdog_reset(wdr), .irq_in(irq),
    .program_pulse(prog_p), .erase_pulse(erase_p), .verify_en(ver),
    .prewrite_verify(prew), .busy(busy), .aborted(abrt),
    .overlap_vectors(ovl), .block_en(blk));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Flags busy, aborted, program, erase, prewrite; then block enables
  task automatic ochk(input logic [4:0] f, input logic [11:0] b);
    chk({15'h0, busy, abrt, prog_p, erase_p, prew, blk}, {15'h0, f, b});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_fpep_proc.xfer(1'b1, a, d, q);
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    u_fpep_proc.xfer(1'b0, a, 8'h00, q);
    #1;
    chk(q, e);
  endtask
  task automatic do_reset(input int n);
    hresetn <= 1'b0;
    repeat (n) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
  endtask
  // Large block 0 selected, program bit set
  task automatic arm();
    wr(FPEP_OFS_BLK_FIRST, 8'h01);
    wr(FPEP_OFS_CTRL, 8'h01);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_vals();
    rdc(FPEP_OFS_CTRL, 32'h00);
    rdc(FPEP_OFS_BLK_FIRST, 32'hF0);
    rdc(FPEP_OFS_BLK_SECOND, 32'h00);
    rdc(FPEP_OFS_WAIT, 32'h08);
    rdc(FPEP_OFS_STATUS, 32'h04);
    ochk(5'b00001, 12'h000);
    chk({31'h0, ver}, 32'h1);
  endtask
  task automatic t_prog_erase();
    arm();
    ochk(5'b10100, 12'h100);
    rdc(FPEP_OFS_STATUS, 32'h05);
    wr(FPEP_OFS_CTRL, 8'h02);
    ochk(5'b10010, 12'h100);
    wr(FPEP_OFS_CTRL, 8'h03);
    ochk(5'b10100, 12'h100);
    wr(FPEP_OFS_CTRL, 8'h04);
    ochk(5'b00000, 12'h100);
    wr(FPEP_OFS_CTRL, 8'h00);
    ochk(5'b00001, 12'h100);
  endtask
  task automatic t_block_protect();
    wr(FPEP_OFS_BLK_FIRST, 8'hF0);
    wr(FPEP_OFS_CTRL, 8'h01);
    ochk(5'b10000, 12'h000);
    wr(FPEP_OFS_CTRL, 8'h08);
    chk({31'h0, ver}, 32'h1);
    wr(FPEP_OFS_BLK_SECOND, 8'h80);
    wr(FPEP_OFS_CTRL, 8'h02);
    ochk(5'b10010, 12'h080);
    wr(FPEP_OFS_CTRL, 8'h00);
  endtask
  task automatic t_emulation();
    wr(FPEP_OFS_BLK_SECOND, 8'hFF);
    for (int i = 0; i < 2; i++) begin
      wr(FPEP_OFS_WAIT, i ? 8'h80 : 8'h40);
      wr(FPEP_OFS_CTRL, 8'h01);
      ochk(5'b10000, 12'h000);
      wr(FPEP_OFS_CTRL, 8'h04);
      chk({31'h0, ver}, 32'h1);
    end
    wr(FPEP_OFS_CTRL, 8'h00);
    wr(FPEP_OFS_WAIT, 8'hC0);
    chk({31'h0, ovl}, 32'h1);
    ochk(5'b00001, 12'h0FF);
    wr(FPEP_OFS_WAIT, 8'h08);
  endtask
  task automatic t_hw_protect();
    for (int k = 0; k < 3; k++) begin
      arm();
      @(posedge hclk);
      vpp <= (k != 0);
      stby <= (k == 1);
      wdr <= (k == 2);
      @(posedge hclk);
      #1;
      ochk(5'b00000, 12'h000);
      chk({31'h0, ver}, 32'h0);
      @(posedge hclk);
      vpp <= 1'b1;
      stby <= 1'b0;
      wdr <= 1'b0;
      @(posedge hclk);
      #1;
      rdc(FPEP_OFS_CTRL, 32'h00);
      rdc(FPEP_OFS_BLK_FIRST, 32'hF0);
    end
  endtask
  task automatic t_abort();
    arm();
    @(posedge hclk);
    irq <= 1'b1;
    @(posedge hclk);
    irq <= 1'b0;
    #1;
    ochk(5'b11000, 12'h000);
    rdc(FPEP_OFS_CTRL, 32'h01);
    rdc(FPEP_OFS_BLK_FIRST, 32'hF1);
    wr(FPEP_OFS_CTRL, 8'h04);
    chk({31'h0, ver}, 32'h1);
    wr(FPEP_OFS_CTRL, 8'h01);
    ochk(5'b11000, 12'h000);
    do_reset(10);
    ochk(5'b00001, 12'h000);
  endtask
  // Program then erase one block the way the routine does it
  task automatic t_routine();
    wr(FPEP_OFS_WAIT, 8'h00);
    wr(FPEP_OFS_BLK_FIRST, 8'h01);
    u_fpep_proc.start_pulse(8'h01);
    #1;
    ochk(5'b10100, 12'h100);
    u_fpep_proc.enter_verify(8'h00);
    #1;
    ochk(5'b00001, 12'h100);
    chk({31'h0, ver}, 32'h1);
    u_fpep_proc.start_pulse(8'h02);
    #1;
    ochk(5'b10010, 12'h100);
    u_fpep_proc.enter_verify(8'h08);
    #1;
    ochk(5'b00000, 12'h100);
    chk({31'h0, ver}, 32'h1);
    wr(FPEP_OFS_CTRL, 8'h00);
    wr(FPEP_OFS_WAIT, 8'h08);
  endtask
  task automatic t_unmapped();
    wr(8'h20, 8'h55);
    rdc(8'h20, 32'h00);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // Sequence, verdict and watchdog
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    do_reset(2);
    t_reset_vals();
    t_prog_erase();
    t_block_protect();
    t_emulation();
    t_hw_protect();
    t_routine();
    t_abort();
    t_unmapped();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
